// *** core/emp_pkg.sv ***
// shared constants and types for the external memory pin controller
package emp_pkg;

	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int unsigned EMP_BUS_W   = 24;
	localparam int unsigned EMP_LSB_W   = 3;
	localparam int unsigned EMP_GPIO_W  = 27;
	localparam int unsigned EMP_GPL_W   = 6;
	localparam int unsigned EMP_EAD_W   = 4;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int unsigned EMP_GPL_TERM_BIT = 4;
	localparam int unsigned EMP_GPL_FIVE_BIT = 5;
	localparam int unsigned EMP_GPIO_LSB_POS = 24;

	// ---------------------------------------------------------------
	// timing: bus clock is the core clock divided by two
	// ---------------------------------------------------------------
	localparam int unsigned EMP_CORE_PERIOD_NS = 8;
	localparam int unsigned EMP_BUS_PERIOD_NS  = 16;
	localparam int unsigned EMP_HALF_BUS_CYC   =
		(EMP_BUS_PERIOD_NS / 2 + EMP_CORE_PERIOD_NS - 1) / EMP_CORE_PERIOD_NS;
	localparam int unsigned EMP_LOCK_EDGES     = 8;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [EMP_GPIO_W-1:0] EMP_CONN_RST = 27'h000_0000;
	localparam logic [EMP_GPIO_W-1:0] EMP_DIR_RST  = 27'h000_0000;
	localparam logic                  EMP_BCTL_RST = 1'b1;
	localparam logic                  EMP_CKE_RST  = 1'b1;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		EMP_MC_CHIP_SELECT  = 2'h0,
		EMP_MC_PROGRAMMABLE = 2'h1,
		EMP_MC_SDRAM        = 2'h2
	} emp_machine_t;

	typedef enum logic [3:0] {
		EMP_ST_IDLE = 4'h1,
		EMP_ST_ALE  = 4'h2,
		EMP_ST_DATA = 4'h4,
		EMP_ST_DONE = 4'h8
	} emp_state_t;

endpackage : emp_pkg

// *** core/emp_deskew.sv ***
// deskew loop logic clocked by the returned sync clock
`timescale 1ns/100ps
module emp_deskew
	import emp_pkg::*;
#(
	parameter int unsigned LOCK_EDGES = EMP_LOCK_EDGES
) (
	input  wire logic link_clk_i,
	input  wire logic reset_i,
	output logic      lead_clk_o,
	output logic      locked_o
);

	logic       rst_meta;
	logic       rst_link;
	logic [7:0] edge_cnt;

	// ---------------------------------------------------------------
	// reset crossing into the loop domain
	// ---------------------------------------------------------------
	always_ff @(posedge link_clk_i) begin
		rst_meta <= reset_i;
		rst_link <= rst_meta;
	end

	// ---------------------------------------------------------------
	// lock detection: loop must return a run of edges
	// ---------------------------------------------------------------
	always_ff @(posedge link_clk_i) begin
		if (rst_link) begin
			edge_cnt <= 8'h00;
			locked_o <= 1'b0;
		end else if (edge_cnt == 8'(LOCK_EDGES - 1)) begin
			locked_o <= 1'b1;
		end else begin
			edge_cnt <= edge_cnt + 8'h01;
		end
	end

	// ---------------------------------------------------------------
	// lead clock taken from the loop return, so it is early by the loop delay
	// ---------------------------------------------------------------
	always_ff @(posedge link_clk_i) begin
		if (rst_link) begin
			lead_clk_o <= 1'b0;
		end else if (locked_o) begin
			lead_clk_o <= ~lead_clk_o;
		end
	end

endmodule : emp_deskew

// *** core/emp_pins.sv ***
// pin side of the external memory controller
// Behaviour
// RULE_01 - chip-select mode: terminate input ends transaction
// RULE_02 - line four is output or wait input
// RULE_03 - line five drives current pattern entry
// RULE_04 - buffer control active for chip-select/programmable banks
// RULE_05 - sdram banks leave buffer control inactive
// RULE_06 - per-bank disable suppresses buffer control
// RULE_07 - buffer control high after reset, address phase
// RULE_08 - external buffer silent while control high
// RULE_09 - low address bits always on dedicated pins
// RULE_10 - low pins carry incrementing burst offset
// RULE_11 - gpio: low address pins programmable, start disconnected
// RULE_12 - gpio: shared bus lines programmable, start disconnected
// RULE_13 - one shared 24-bit address/data bus
// RULE_14 - address driven while latch enable high
// RULE_15 - external latch passes, then captures address
// RULE_16 - after latch: drive write data or release
// RULE_17 - bus released after final write beat
// RULE_18 - 32-bit port uses all 24 lines
// RULE_19 - sdram clock enable held in normal operation
// RULE_20 - memory clock leads when loop not bypassed (code: bus clock until pll_locked_o is high)
// RULE_21 - sync out copies bus clock into loop
// RULE_22 - latch enable length; other controls idle meanwhile
`timescale 1ns/100ps
module emp_pins
	import emp_pkg::*;
#(
	parameter int unsigned BUS_W      = EMP_BUS_W,
	parameter int unsigned LOCK_EDGES = EMP_LOCK_EDGES
) (
	input  wire logic                  core_clk_i,
	input  wire logic                  reset_i,
	input  wire logic                  deskew_sync_in_i,
	input  wire logic                  gpio_mode_i,
	input  wire logic                  cfg_load_i,
	input  wire logic [EMP_GPIO_W-1:0] cfg_conn_i,
	input  wire logic [EMP_GPIO_W-1:0] cfg_dir_i,
	input  wire logic [EMP_GPIO_W-1:0] gpio_out_i,
	output logic      [EMP_GPIO_W-1:0] gpio_in_o,
	input  wire logic                  pll_bypass_i,
	input  wire logic                  upm_wait_sel_i,
	input  wire logic                  sdram_powerdown_i,
	input  wire logic [EMP_GPL_W-1:0]  upm_gpl_i,
	input  wire logic                  req_valid_i,
	output logic                       req_ready_o,
	input  wire logic                  req_write_i,
	input  wire logic [1:0]            req_machine_i,
	input  wire logic                  req_bctl_disable_i,
	input  wire logic                  req_ead_i,
	input  wire logic [EMP_EAD_W-1:0]  ead_cycles_i,
	input  wire logic [EMP_LSB_W-1:0]  req_last_beat_i,
	input  wire logic [BUS_W-1:0]      req_addr_i,
	input  wire logic [BUS_W-1:0]      wr_data_i,
	output logic                       wr_take_o,
	output logic      [BUS_W-1:0]      rd_data_o,
	output logic                       rd_valid_o,
	output logic                       done_o,
	input  wire logic [BUS_W-1:0]      shared_addr_data_bus_i,
	output logic      [BUS_W-1:0]      shared_addr_data_bus_o,
	output logic      [BUS_W-1:0]      shared_addr_data_bus_oe_o,
	input  wire logic [EMP_LSB_W-1:0]  address_lsb_pins_i,
	output logic      [EMP_LSB_W-1:0]  address_lsb_pins_o,
	output logic      [EMP_LSB_W-1:0]  address_lsb_pins_oe_o,
	input  wire logic                  terminate_access_input_i,
	output logic                       general_line_four_o,
	output logic                       general_line_four_oe_o,
	input  wire logic                  general_line_five_i,
	output logic                       general_line_five_o,
	output logic                       general_line_five_oe_o,
	output logic                       address_latch_enable_o,
	output logic                       data_buffer_control_o,
	output logic                       sdram_clock_enable_o,
	output logic                       memory_clock_out_o,
	output logic                       deskew_sync_out_o,
	output logic                       pll_locked_o
);

	localparam int unsigned PIN_W = BUS_W + EMP_LSB_W + 2;

	emp_state_t             state;
	emp_state_t             next_state;
	emp_machine_t           mach;
	logic                   write_q;
	logic                   no_bctl;
	logic [EMP_LSB_W-1:0]   beat;
	logic [EMP_LSB_W-1:0]   last_beat;
	logic [EMP_EAD_W:0]     ale_cnt;
	logic [EMP_GPIO_W-1:0]  conn;
	logic [EMP_GPIO_W-1:0]  dir;
	logic [PIN_W-1:0]       pin_meta;
	logic [PIN_W-1:0]       pin_sync;
	logic                   term_act;
	logic                   accept;
	logic                   step;
	logic                   last;
	logic                   gpio_idle;
	logic                   bus_clk;
	logic                   lead_clk;
	logic                   lock_link;
	logic                   lock_meta;
	logic [3:0]             pend;

	// ---------------------------------------------------------------
	// pin input synchronisers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		pin_meta <= {general_line_five_i, terminate_access_input_i,
			address_lsb_pins_i, shared_addr_data_bus_i};
		pin_sync <= pin_meta;
	end

	// terminate pin is active low and only read when not driven
	assign term_act    = ~pin_sync[PIN_W-2] & ~general_line_four_oe_o;
	assign gpio_idle   = gpio_mode_i && (state == EMP_ST_IDLE);
	assign req_ready_o = (state == EMP_ST_IDLE) && !gpio_mode_i;
	assign accept      = req_valid_i && req_ready_o;
	assign last        = (mach == EMP_MC_CHIP_SELECT) || (beat == last_beat);

	// ---------------------------------------------------------------
	// beat advance per machine
	// ---------------------------------------------------------------
	always_comb begin
		step = 1'b0;
		if (state == EMP_ST_DATA) begin
			case (mach)
				// RULE_01 terminate ends access
				EMP_MC_CHIP_SELECT:  step = term_act;
				// RULE_02 wait input stalls
				EMP_MC_PROGRAMMABLE: step = !(upm_wait_sel_i && term_act);
				default:             step = 1'b1;
			endcase
		end
	end

	assign wr_take_o = write_q && (((state == EMP_ST_ALE) && (ale_cnt == '0))
		|| (step && !last));

	// ---------------------------------------------------------------
	// access sequencer
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			EMP_ST_IDLE: if (accept) next_state = EMP_ST_ALE;
			EMP_ST_ALE:  if (ale_cnt == '0) next_state = EMP_ST_DATA;
			EMP_ST_DATA: if (step && last) next_state = EMP_ST_DONE;
			EMP_ST_DONE: next_state = EMP_ST_IDLE;
			default:     next_state = EMP_ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state <= EMP_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ---------------------------------------------------------------
	// access attributes
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			mach      <= EMP_MC_CHIP_SELECT;
			write_q   <= 1'b0;
			no_bctl   <= 1'b0;
			last_beat <= '0;
		end else if (accept) begin
			mach      <= emp_machine_t'(req_machine_i);
			write_q   <= req_write_i;
			// RULE_05 RULE_06 buffer control suppressed
			no_bctl   <= (req_machine_i == EMP_MC_SDRAM) || req_bctl_disable_i;
			last_beat <= req_last_beat_i;
		end
	end

	// ---------------------------------------------------------------
	// latch enable length: half bus clock, or N and a half
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ale_cnt <= '0;
		end else if (accept) begin
			// RULE_22 latch enable length
			ale_cnt <= req_ead_i ? {ead_cycles_i, 1'b0} + 5'(EMP_HALF_BUS_CYC - 1)
				: 5'(EMP_HALF_BUS_CYC - 1);
		end else if ((state == EMP_ST_ALE) && (ale_cnt != '0)) begin
			ale_cnt <= ale_cnt - 5'h01;
		end
	end

	// ---------------------------------------------------------------
	// beat counter and dedicated low address pins
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			beat <= '0;
		end else if (accept) begin
			beat <= '0;
		end else if (step && !last) begin
			beat <= beat + 3'h1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			// RULE_11 pins start disconnected
			address_lsb_pins_o    <= '0;
			address_lsb_pins_oe_o <= '0;
		end else if (gpio_idle) begin
			address_lsb_pins_o    <= gpio_out_i[EMP_GPIO_W-1:EMP_GPIO_LSB_POS];
			address_lsb_pins_oe_o <= conn[EMP_GPIO_W-1:EMP_GPIO_LSB_POS]
				& dir[EMP_GPIO_W-1:EMP_GPIO_LSB_POS];
		end else begin
			// RULE_09 low bits always driven
			address_lsb_pins_oe_o <= '1;
			if (accept) begin
				address_lsb_pins_o <= req_addr_i[EMP_LSB_W-1:0];
			end else if (step && !last) begin
				// RULE_10 burst offset increments
				address_lsb_pins_o <= address_lsb_pins_o + 3'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// shared bus, latch enable and buffer control
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			shared_addr_data_bus_o    <= '0;
			shared_addr_data_bus_oe_o <= '0;
			address_latch_enable_o    <= 1'b0;
			// RULE_07 high from reset
			data_buffer_control_o     <= EMP_BCTL_RST;
		end else if (gpio_idle) begin
			// RULE_12 bus lines as gpio
			shared_addr_data_bus_o    <= gpio_out_i[BUS_W-1:0];
			shared_addr_data_bus_oe_o <= conn[BUS_W-1:0] & dir[BUS_W-1:0];
			address_latch_enable_o    <= 1'b0;
			data_buffer_control_o     <= 1'b1;
		end else if (accept) begin
			// RULE_13 RULE_14 address on shared bus
			shared_addr_data_bus_o    <= req_addr_i;
			shared_addr_data_bus_oe_o <= '1;
			address_latch_enable_o    <= 1'b1;
			data_buffer_control_o     <= 1'b1;
		end else if (state == EMP_ST_ALE && next_state == EMP_ST_DATA) begin
			// RULE_16 write data or release
			address_latch_enable_o    <= 1'b0;
			shared_addr_data_bus_oe_o <= write_q ? '1 : '0;
			if (write_q) begin
				shared_addr_data_bus_o <= wr_data_i;
			end
			// RULE_04 read direction while active
			data_buffer_control_o     <= write_q || no_bctl;
		end else if (state == EMP_ST_DATA) begin
			if (wr_take_o) begin
				shared_addr_data_bus_o <= wr_data_i;
			end
			if (step && last) begin
				// RULE_17 release after last beat
				shared_addr_data_bus_oe_o <= '0;
				data_buffer_control_o     <= 1'b1;
			end
		end else if (state != EMP_ST_ALE) begin
			shared_addr_data_bus_oe_o <= '0;
			data_buffer_control_o     <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// read data, completion
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		pend <= {pend[1:0], step && last, step && !write_q};
		if (reset_i) begin
			rd_data_o  <= '0;
			rd_valid_o <= 1'b0;
			done_o     <= 1'b0;
		end else begin
			rd_valid_o <= pend[2];
			done_o     <= pend[3];
			if (pend[2]) begin
				rd_data_o <= pin_sync[BUS_W-1:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// general purpose lines four and five
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			general_line_four_o    <= 1'b1;
			general_line_four_oe_o <= 1'b0;
			general_line_five_o    <= 1'b1;
			general_line_five_oe_o <= 1'b0;
		end else if (next_state == EMP_ST_DATA && mach == EMP_MC_PROGRAMMABLE) begin
			// RULE_03 pattern entry on line five
			general_line_five_o    <= upm_gpl_i[EMP_GPL_FIVE_BIT];
			general_line_five_oe_o <= 1'b1;
			// RULE_02 line four as output
			general_line_four_o    <= upm_gpl_i[EMP_GPL_TERM_BIT];
			general_line_four_oe_o <= !upm_wait_sel_i;
		end else begin
			// RULE_22 idle while latch enable high
			general_line_four_o    <= 1'b1;
			general_line_four_oe_o <= 1'b0;
			general_line_five_o    <= 1'b1;
			general_line_five_oe_o <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// gpio configuration and input view
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			conn <= EMP_CONN_RST;
			dir  <= EMP_DIR_RST;
		end else if (cfg_load_i) begin
			conn <= cfg_conn_i;
			dir  <= cfg_dir_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			gpio_in_o <= '0;
		end else begin
			gpio_in_o <= pin_sync[EMP_GPIO_W-1:0] & conn & ~dir & {EMP_GPIO_W{gpio_mode_i}};
		end
	end

	// ---------------------------------------------------------------
	// clocks: bus clock replica, sdram enable, deskew loop
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			bus_clk              <= 1'b0;
			sdram_clock_enable_o <= EMP_CKE_RST;
		end else begin
			bus_clk              <= ~bus_clk;
			// RULE_19 enable held in normal operation
			sdram_clock_enable_o <= !sdram_powerdown_i;
		end
	end

	// RULE_21 bus clock copy into loop
	assign deskew_sync_out_o = bus_clk;

	emp_deskew #(
		.LOCK_EDGES (LOCK_EDGES)
	) u_deskew (
		.link_clk_i (deskew_sync_in_i),
		.reset_i    (reset_i),
		.lead_clk_o (lead_clk),
		.locked_o   (lock_link)
	);

	always_ff @(posedge core_clk_i) begin
		lock_meta    <= lock_link;
		pll_locked_o <= lock_meta;
	end

	// RULE_20 loop return gives the early clock
	assign memory_clock_out_o = (pll_bypass_i || !pll_locked_o) ? bus_clk : lead_clk;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	logic [EMP_EAD_W:0] ale_len;
	logic [EMP_EAD_W:0] ale_want;

	always_ff @(posedge core_clk_i) begin
		if (reset_i || accept) begin
			ale_len  <= '0;
			ale_want <= req_ead_i ? {ead_cycles_i, 1'b0} : '0;
		end else if (address_latch_enable_o) begin
			ale_len <= ale_len + 5'h01;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	property p_ale_len;
		$fell(address_latch_enable_o) |-> ale_len == ale_want + 5'(EMP_HALF_BUS_CYC);
	endproperty
	a_ale_len: assert property (p_ale_len) else $error("latch enable wrong length"); // RULE_22

	property p_ale_quiet;
		address_latch_enable_o |-> data_buffer_control_o && !general_line_five_oe_o
			&& !general_line_four_oe_o;
	endproperty
	a_ale_quiet: assert property (p_ale_quiet) else $error("control active in addr phase"); // RULE_07

	property p_ale_addr;
		accept |=> address_latch_enable_o && shared_addr_data_bus_o == $past(req_addr_i)
			&& &shared_addr_data_bus_oe_o;
	endproperty
	a_ale_addr: assert property (p_ale_addr) else $error("address not on bus"); // RULE_14

	property p_bctl_read;
		(state == EMP_ST_DATA && !write_q && !no_bctl) |-> !data_buffer_control_o;
	endproperty
	a_bctl_read: assert property (p_bctl_read) else $error("buffer control not active"); // RULE_04

	property p_bctl_off;
		no_bctl && state != EMP_ST_IDLE |-> data_buffer_control_o;
	endproperty
	a_bctl_off: assert property (p_bctl_off) else $error("buffer control should be off"); // RULE_06

	property p_release;
		done_o |-> shared_addr_data_bus_oe_o == '0 ##1 shared_addr_data_bus_oe_o == '0;
	endproperty
	a_release: assert property (p_release) else $error("bus not released"); // RULE_17

	property p_term;
		(state == EMP_ST_DATA && mach == EMP_MC_CHIP_SELECT && term_act) |=> ##2 done_o ##1 !done_o;
	endproperty
	a_term: assert property (p_term) else $error("terminate did not end access"); // RULE_01

	property p_wait;
		(state == EMP_ST_DATA && mach == EMP_MC_PROGRAMMABLE && upm_wait_sel_i && term_act)
			|=> $stable(beat) && !done_o;
	endproperty
	a_wait: assert property (p_wait) else $error("wait did not stall"); // RULE_02

	property p_burst;
		(step && !last) |=> address_lsb_pins_o == $past(address_lsb_pins_o) + 3'h1;
	endproperty
	a_burst: assert property (p_burst) else $error("burst offset not incremented"); // RULE_10

	property p_cke;
		!sdram_powerdown_i [*2] |-> sdram_clock_enable_o;
	endproperty
	a_cke: assert property (p_cke) else $error("clock enable dropped"); // RULE_19

endmodule : emp_pins

// *** dv/emp_mem_model.sv ***
// pin-side model of external memory and address latch
`timescale 1ns/100ps
module emp_mem_model
	import emp_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic [7:0]           term_dly_i,
	input  wire logic                 ale_i,
	input  wire logic [EMP_BUS_W-1:0] bus_i,
	input  wire logic [EMP_BUS_W-1:0] bus_oe_i,
	input  wire logic [EMP_LSB_W-1:0] lsb_i,
	input  wire logic [EMP_LSB_W-1:0] lsb_oe_i,
	input  wire logic                 five_i,
	input  wire logic                 five_oe_i,
	output logic      [EMP_BUS_W-1:0] bus_o,
	output logic      [EMP_LSB_W-1:0] lsb_o,
	output logic                      five_o,
	output logic                      term_n_o
);
	logic [EMP_BUS_W-1:0] latched;
	logic                 drv;
	int                   cnt = 1000;
	always_ff @(posedge clk_i) begin
		if (ale_i) begin
			latched <= bus_i;
			cnt     <= 0;
		end else if (cnt < 1000) begin
			cnt <= cnt + 1;
		end
	end
	assign drv = !ale_i && bus_oe_i == '0 && cnt < 40;
	assign bus_o = (bus_i & bus_oe_i) |
		((drv ? {latched[23:3], lsb_i} ^ 24'h5A_5A5A : 24'h00_0000) & ~bus_oe_i);
	assign lsb_o = lsb_i & lsb_oe_i;
	assign five_o = five_oe_i ? five_i : 1'b1;
	assign term_n_o = !(cnt >= int'(term_dly_i) && cnt < int'(term_dly_i) + 4);
endmodule : emp_mem_model

// *** dv/tb_emp_pins.sv ***
// self-checking bench for the external memory pin controller
`timescale 1ns/100ps
module tb_emp_pins
	import emp_pkg::*;
;
	logic                  core_clk_i, link_clk, s;
	logic                  reset_i = 1'b1, gpio_mode_i = 1'b1, cfg_load_i = 1'b0;
	logic [EMP_GPIO_W-1:0] cfg_conn_i = '0, cfg_dir_i = '0, gpio_out_i = '0, gpio_in_o, m;
	logic                  pll_bypass_i = 1'b0, upm_wait_sel_i = 1'b0, sdram_powerdown_i = 1'b0;
	logic [5:0]            upm_gpl_i = '0;
	logic                  req_valid_i = 1'b0, req_write_i = 1'b0, req_bctl_disable_i = 1'b0;
	logic                  req_ead_i = 1'b0, req_ready_o, wr_take_o, rd_valid_o, done_o;
	logic [1:0]            req_machine_i = '0;
	logic [3:0]            ead_cycles_i = '0;
	logic [2:0]            req_last_beat_i = '0, address_lsb_pins_i, address_lsb_pins_o;
	logic [2:0]            address_lsb_pins_oe_o;
	logic [23:0]           req_addr_i = '0, wr_data_i = '0, rd_data_o, shared_addr_data_bus_i;
	logic [23:0]           shared_addr_data_bus_o, shared_addr_data_bus_oe_o;
	logic                  terminate_access_input_i, general_line_four_o, general_line_four_oe_o;
	logic                  general_line_five_i, general_line_five_o, general_line_five_oe_o;
	logic                  address_latch_enable_o, data_buffer_control_o, sdram_clock_enable_o;
	logic                  memory_clock_out_o, deskew_sync_out_o, pll_locked_o;
	logic [7:0]            term_dly = 8'h01;
	int                    seed = 61419, num_errors = 0, samples_checked = 0, cycles = 0;

	emp_pins DUT (
		.core_clk_i, .reset_i, .deskew_sync_in_i(link_clk), .gpio_mode_i, .cfg_load_i,
		.cfg_conn_i, .cfg_dir_i, .gpio_out_i, .gpio_in_o, .pll_bypass_i, .upm_wait_sel_i,
		.sdram_powerdown_i, .upm_gpl_i, .req_valid_i, .req_ready_o, .req_write_i,
		.req_machine_i, .req_bctl_disable_i, .req_ead_i, .ead_cycles_i, .req_last_beat_i,
		.req_addr_i, .wr_data_i, .wr_take_o, .rd_data_o, .rd_valid_o, .done_o,
		.shared_addr_data_bus_i, .shared_addr_data_bus_o, .shared_addr_data_bus_oe_o,
		.address_lsb_pins_i, .address_lsb_pins_o, .address_lsb_pins_oe_o,
		.terminate_access_input_i, .general_line_four_o, .general_line_four_oe_o,
		.general_line_five_i, .general_line_five_o, .general_line_five_oe_o,
		.address_latch_enable_o, .data_buffer_control_o, .sdram_clock_enable_o,
		.memory_clock_out_o, .deskew_sync_out_o, .pll_locked_o
	);

	emp_mem_model u_mem (
		.clk_i(core_clk_i), .term_dly_i(term_dly), .ale_i(address_latch_enable_o),
		.bus_i(shared_addr_data_bus_o), .bus_oe_i(shared_addr_data_bus_oe_o),
		.lsb_i(address_lsb_pins_o), .lsb_oe_i(address_lsb_pins_oe_o),
		.five_i(general_line_five_o), .five_oe_i(general_line_five_oe_o),
		.bus_o(shared_addr_data_bus_i), .lsb_o(address_lsb_pins_i),
		.five_o(general_line_five_i), .term_n_o(terminate_access_input_i)
	);

	// ---------------------------------------------------------------
	// clocks and watchdog
	// ---------------------------------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end
	initial begin
		link_clk = 1'b0;
		#5.3;
		forever #32 link_clk = ~link_clk;
	end
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			give_verdict();
		end
	end

	// ---------------------------------------------------------------
	// compare and verdict
	// ---------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict

	// one random memory access, watched cycle by cycle
	task automatic run_access();
		logic [1:0]  mc;
		logic        wr, dis, ead, low, term;
		logic [3:0]  n;
		logic [2:0]  lb;
		logic [23:0] a, wd;
		logic [5:0]  gpl;
		int          ale_n, rd_n, cyc;
		mc = 2'($unsigned($random(seed)) % 3);
		wr = 1'($random(seed));
		dis = 1'($random(seed));
		ead = 1'($random(seed));
		n = 4'($random(seed) & 3);
		lb = (mc == 2'h0) ? 3'h0 : 3'($random(seed) & 3);
		a = 24'($random(seed)) & 24'hFF_FFFC;
		wd = 24'($random(seed));
		gpl = 6'($random(seed));
		ale_n = 0;
		rd_n = 0;
		low = 1'b0;
		term = 1'b0;
		@(posedge core_clk_i);
		req_valid_i <= 1'b1;
		req_write_i <= wr;
		req_machine_i <= mc;
		req_bctl_disable_i <= dis;
		req_ead_i <= ead;
		ead_cycles_i <= n;
		req_last_beat_i <= lb;
		req_addr_i <= a;
		wr_data_i <= wd;
		upm_gpl_i <= gpl;
		term_dly <= 8'(1 + ($random(seed) & 3));
		@(negedge core_clk_i);
		for (cyc = 0; cyc < 20 && req_ready_o !== 1'b1; cyc++) @(negedge core_clk_i);
		@(posedge core_clk_i);
		req_valid_i <= 1'b0;
		for (cyc = 0; cyc < 200; cyc++) begin
			@(negedge core_clk_i);
			if (address_latch_enable_o === 1'b1) begin
				ale_n++;
				check("ale addr", shared_addr_data_bus_o, a);
				check("ale oe", shared_addr_data_bus_oe_o, 24'hFF_FFFF);
				check("ale bctl", data_buffer_control_o, 1);
				check("ale lsb", address_lsb_pins_o, a[2:0]);
				check("ale five", general_line_five_oe_o, 0);
			end else if (wr && shared_addr_data_bus_oe_o === 24'hFF_FFFF) begin
				check("wr data", shared_addr_data_bus_o, wd);
			end
			if (data_buffer_control_o === 1'b0) low = 1'b1;
			if (terminate_access_input_i === 1'b0) term = 1'b1;
			if (mc == 2'h1 && general_line_five_oe_o === 1'b1) begin
				check("line five", general_line_five_o, gpl[5]);
				check("line four", general_line_four_o, gpl[4]);
			end
			if (rd_valid_o === 1'b1) begin
				check("rd data", rd_data_o, {a[23:3], a[2:0] + 3'(rd_n)} ^ 24'h5A_5A5A);
				rd_n++;
			end
			if (done_o === 1'b1) break;
		end
		check("ale len", ale_n, ead ? 2 * n + 1 : 1);
		check("bctl", low, !wr && mc != 2'h2 && !dis);
		check("beats", rd_n, wr ? 0 : lb + 1);
		if (mc == 2'h0) check("term", term, 1);
		@(negedge core_clk_i);
		check("released", shared_addr_data_bus_oe_o, 0);
	endtask : run_access

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (12) @(posedge core_clk_i);
		reset_i <= 1'b0;
		@(negedge core_clk_i);
		check("bctl rst", data_buffer_control_o, 1);
		check("cke rst", sdram_clock_enable_o, 1);
		check("bus oe rst", shared_addr_data_bus_oe_o, 0);
		check("lsb oe rst", address_lsb_pins_oe_o, 0);
		s = deskew_sync_out_o;
		@(negedge core_clk_i);
		check("sync out", deskew_sync_out_o, !s);
		@(posedge core_clk_i);
		cfg_conn_i <= 27'($random(seed));
		cfg_dir_i <= 27'($random(seed));
		gpio_out_i <= 27'($random(seed));
		cfg_load_i <= 1'b1;
		@(posedge core_clk_i);
		cfg_load_i <= 1'b0;
		repeat (4) @(negedge core_clk_i);
		m = cfg_conn_i & cfg_dir_i;
		check("bus oe", shared_addr_data_bus_oe_o, m[23:0]);
		check("bus out", shared_addr_data_bus_o & m[23:0], gpio_out_i[23:0] & m[23:0]);
		check("lsb oe", address_lsb_pins_oe_o, m[26:24]);
		check("lsb out", address_lsb_pins_o & m[26:24], gpio_out_i[26:24] & m[26:24]);
		check("gpio in", gpio_in_o, 0);
		@(posedge core_clk_i);
		gpio_mode_i <= 1'b0;
		sdram_powerdown_i <= 1'b1;
		repeat (3) @(negedge core_clk_i);
		check("cke off", sdram_clock_enable_o, 0);
		@(posedge core_clk_i);
		sdram_powerdown_i <= 1'b0;
		repeat (3) @(negedge core_clk_i);
		check("cke on", sdram_clock_enable_o, 1);
		check("lsb oe", address_lsb_pins_oe_o, 3'h7);
		repeat (40) run_access();
		check("locked", pll_locked_o, 1);
		give_verdict();
	end
endmodule : tb_emp_pins
